// >>> hdl/balu_core.sv
// Byte arithmetic and logic unit: sequencer, status flags and write-back.
// Assumes decoder and register file on the same clock and reset.
//
// Contract
// RL1 - Add and add-with-carry sum two registers, write back and set Z C N V H in one cycle.
// RL2 - Word add of an immediate to a register pair sets Z C N V S and takes two cycles.
// RL3 - Register subtract, with or without carry, sets Z C N V H in one cycle.
// RL4 - Immediate subtract, with or without carry, sets Z C N V H in one cycle.
// RL5 - Word subtract of an immediate from a register pair sets Z C N V S in two cycles.
// RL6 - AND with a register or constant sets only Z N V in one cycle.
// RL7 - OR with a register or constant, or XOR with a register, sets Z N V in one cycle.
// RL8 - Ones complement gives all ones minus the value and sets Z C N V in one cycle.
// RL9 - Twos complement gives zero minus the value and sets Z C N V H in one cycle.
// RL10 - Set-mask ORs an immediate into the register and sets Z N V in one cycle.
// RL11 - Clear-mask ANDs with the inverted mask and sets Z N V in one cycle.
// RL12 - Increment and decrement set Z N V, leave carry alone, in one cycle.
// RL13 - Flags an operation does not name hold, and results land at its last cycle.
`timescale 1ns/1ps
`default_nettype none
module balu_core (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              start,
  input  wire balu_pkg::balu_op_t op,
  input  wire logic [7:0]        dst_val,
  input  wire logic [7:0]        dst_hi_val,
  input  wire logic [7:0]        src_val,
  input  wire logic [7:0]        imm_val,
  input  wire logic              flag_wr,
  input  wire logic [5:0]        flag_in,
  output logic [7:0]             res_lo_q,
  output logic [7:0]             res_hi_q,
  output logic                   wr_lo_q,
  output logic                   wr_hi_q,
  output logic [5:0]             flags_q,
  output logic                   done_q,
  output logic                   busy_q
);
  import balu_pkg::*;

  balu_state_t state_q, state_d;
  logic [7:0]  res_lo_d;
  logic [7:0]  res_hi_d;
  logic        wr_lo_d;
  logic        wr_hi_d;
  logic [5:0]  flags_d;
  logic        done_d;
  logic        busy_d;
  logic [7:0]  wlo_q, wlo_d;
  logic [7:0]  whi_q, whi_d;
  logic        wcy_q, wcy_d;
  logic        wsub_q, wsub_d;
  balu_fcls_t  fcls;
  logic        use_logic;
  logic        word_go;
  logic [7:0]  byte_res;
  logic        idle_go;

  balu_dp_if dp ();

  // ==========================================================================
  // Datapath leaves
  balu_addsub u_addsub (
    .dp (dp)
  );

  balu_logic u_logic (
    .dp (dp)
  );

  // ==========================================================================
  // Operand routing per operation
  always_comb begin
    dp.add_a   = dst_val;
    dp.add_b   = src_val;
    dp.add_cin = 1'b0;
    dp.add_sub = 1'b0;
    dp.lfn     = LFN_AND;
    dp.lop_a   = dst_val;
    dp.lop_b   = src_val;
    fcls       = FC_NONE;
    use_logic  = 1'b0;
    word_go    = 1'b0;
    if (state_q == ST_WORD_HI) begin
      // High byte of a word op: carry ripples in
      dp.add_a   = whi_q;  // [RL2] [RL5]
      dp.add_b   = ZERO_BYTE;
      dp.add_cin = wcy_q;
      dp.add_sub = wsub_q;
    end else if (start) begin
      case (op)
        sum_op: begin
          fcls = FC_ARITH;  // [RL1]
        end
        add_with_carry_op: begin
          dp.add_cin = flags_q[FLAG_C];  // [RL1]
          fcls       = FC_ARITH;
        end
        difference_op: begin
          dp.add_sub = 1'b1;  // [RL3]
          fcls       = FC_ARITH;
        end
        difference_carry_op: begin
          dp.add_sub = 1'b1;  // [RL3]
          dp.add_cin = flags_q[FLAG_C];
          fcls       = FC_ARITH;
        end
        minus_immediate_op: begin
          dp.add_sub = 1'b1;  // [RL4]
          dp.add_b   = imm_val;
          fcls       = FC_ARITH;
        end
        minus_immediate_carry_op: begin
          dp.add_sub = 1'b1;  // [RL4]
          dp.add_b   = imm_val;
          dp.add_cin = flags_q[FLAG_C];
          fcls       = FC_ARITH;
        end
        word_plus_immediate_op, word_minus_immediate_op: begin
          dp.add_b   = imm_val;  // [RL2] [RL5]
          dp.add_sub = (op == word_minus_immediate_op);
          word_go    = 1'b1;
        end
        conjunction_op, conjunction_immediate_op: begin
          dp.lop_b  = (op == conjunction_op) ? src_val : imm_val;  // [RL6]
          use_logic = 1'b1;
          fcls      = FC_LOGIC;
        end
        disjunction_op, disjunction_immediate_op: begin
          dp.lfn    = LFN_OR;  // [RL7]
          dp.lop_b  = (op == disjunction_op) ? src_val : imm_val;
          use_logic = 1'b1;
          fcls      = FC_LOGIC;
        end
        exclusive_disjunction_op: begin
          dp.lfn    = LFN_XOR;  // [RL7]
          use_logic = 1'b1;
          fcls      = FC_LOGIC;
        end
        invert_all_op: begin
          dp.lfn    = LFN_XOR;  // [RL8]
          dp.lop_b  = ALL_ONES;
          use_logic = 1'b1;
          fcls      = FC_INVERT;
        end
        twos_complement_op: begin
          dp.add_a   = ZERO_BYTE;  // [RL9]
          dp.add_b   = dst_val;
          dp.add_sub = 1'b1;
          fcls       = FC_ARITH;
        end
        set_mask_op: begin
          dp.lfn    = LFN_OR;  // [RL10]
          dp.lop_b  = imm_val;
          use_logic = 1'b1;
          fcls      = FC_LOGIC;
        end
        clear_mask_op: begin
          dp.lop_b  = ALL_ONES ^ imm_val;  // [RL11]
          use_logic = 1'b1;
          fcls      = FC_LOGIC;
        end
        plus_one_op, minus_one_op: begin
          dp.add_b   = ONE_BYTE;  // [RL12]
          dp.add_sub = (op == minus_one_op);
          fcls       = FC_STEP;
        end
        default: begin
          fcls = FC_NONE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Next result, write strobes and flags
  always_comb begin
    byte_res = use_logic ? dp.lop_res : dp.add_sum;
    state_d  = state_q;
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    wr_lo_d  = 1'b0;
    wr_hi_d  = 1'b0;
    flags_d  = flags_q;  // [RL13]
    done_d   = 1'b0;
    wlo_d    = wlo_q;
    whi_d    = whi_q;
    wcy_d    = wcy_q;
    wsub_d   = wsub_q;
    case (state_q)
      ST_IDLE: begin
        if (word_go) begin
          // Low byte now, flags and write-back next cycle
          wlo_d   = dp.add_sum;
          wcy_d   = dp.add_c;
          whi_d   = dst_hi_val;
          wsub_d  = dp.add_sub;
          state_d = ST_WORD_HI;
        end else if (fcls != FC_NONE) begin
          res_lo_d        = byte_res;  // [RL13]
          wr_lo_d         = 1'b1;
          done_d          = 1'b1;
          flags_d[FLAG_Z] = (byte_res == ZERO_BYTE);
          flags_d[FLAG_N] = byte_res[7];
          case (fcls)
            FC_ARITH: begin
              flags_d[FLAG_C] = dp.add_c;  // [RL1] [RL3] [RL4] [RL9]
              flags_d[FLAG_V] = dp.add_v;
              flags_d[FLAG_H] = dp.add_h;
            end
            FC_STEP: begin
              flags_d[FLAG_V] = dp.add_v;  // [RL12]
            end
            FC_INVERT: begin
              flags_d[FLAG_C] = 1'b1;  // [RL8]
              flags_d[FLAG_V] = 1'b0;
            end
            default: begin
              flags_d[FLAG_V] = 1'b0;  // [RL6] [RL7] [RL10] [RL11]
            end
          endcase
        end else if (flag_wr) begin
          flags_d = flag_in;
        end
      end
      ST_WORD_HI: begin
        res_lo_d        = wlo_q;  // [RL2] [RL5]
        res_hi_d        = dp.add_sum;
        wr_lo_d         = 1'b1;
        wr_hi_d         = 1'b1;
        done_d          = 1'b1;
        flags_d[FLAG_Z] = ({dp.add_sum, wlo_q} == {ZERO_BYTE, ZERO_BYTE});
        flags_d[FLAG_C] = dp.add_c;
        flags_d[FLAG_N] = dp.add_sum[7];
        flags_d[FLAG_V] = dp.add_v;
        flags_d[FLAG_S] = dp.add_sum[7] ^ dp.add_v;
        state_d         = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d == ST_WORD_HI);
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q  <= ST_IDLE;
      res_lo_q <= RES_RST;
      res_hi_q <= RES_RST;
      wr_lo_q  <= 1'b0;
      wr_hi_q  <= 1'b0;
      flags_q  <= FLAGS_RST;
      done_q   <= 1'b0;
      busy_q   <= 1'b0;
      wlo_q    <= RES_RST;
      whi_q    <= RES_RST;
      wcy_q    <= 1'b0;
      wsub_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      res_lo_q <= res_lo_d;
      res_hi_q <= res_hi_d;
      wr_lo_q  <= wr_lo_d;
      wr_hi_q  <= wr_hi_d;
      flags_q  <= flags_d;
      done_q   <= done_d;
      busy_q   <= busy_d;
      wlo_q    <= wlo_d;
      whi_q    <= whi_d;
      wcy_q    <= wcy_d;
      wsub_q   <= wsub_d;
    end
  end

  // ==========================================================================
  // Checks
  assign idle_go = start && (state_q == ST_IDLE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_sum;
    idle_go && (op == sum_op) |=> wr_lo_q && !wr_hi_q
      && (res_lo_q == 8'($past(dst_val) + $past(src_val)));
  endproperty
  a_sum: assert property (p_sum) else $error("add result wrong");  // [RL1]

  property p_word_add;
    idle_go && (op == word_plus_immediate_op) |=> busy_q && !wr_lo_q ##1 wr_lo_q
      && wr_hi_q && ({res_hi_q, res_lo_q} == 16'({$past(dst_hi_val, 2),
      $past(dst_val, 2)} + {8'h00, $past(imm_val, 2)}));
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add wrong");  // [RL2]

  property p_diff;
    idle_go && (op == difference_op) |=> (res_lo_q == 8'($past(dst_val) - $past(src_val)))
      && (flags_q[FLAG_C] == ($past(src_val) > $past(dst_val)));
  endproperty
  a_diff: assert property (p_diff) else $error("subtract wrong");  // [RL3]

  property p_sub_imm;
    idle_go && (op == minus_immediate_op) |=> wr_lo_q
      && (res_lo_q == 8'($past(dst_val) - $past(imm_val)));
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");  // [RL4]

  property p_word_sub;
    idle_go && (op == word_minus_immediate_op) |=> !done_q ##1 done_q
      && ({res_hi_q, res_lo_q} == 16'({$past(dst_hi_val, 2), $past(dst_val, 2)}
      - {8'h00, $past(imm_val, 2)}));
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word subtract wrong");  // [RL5]

  property p_and;
    idle_go && (op == conjunction_op) |=> !flags_q[FLAG_V]
      && (res_lo_q == ($past(dst_val) & $past(src_val)));
  endproperty
  a_and: assert property (p_and) else $error("and wrong");  // [RL6]

  property p_xor;
    idle_go && (op == exclusive_disjunction_op) |=> (res_lo_q == ($past(dst_val)
      ^ $past(src_val))) && (flags_q[FLAG_Z] == (res_lo_q == ZERO_BYTE));
  endproperty
  a_xor: assert property (p_xor) else $error("xor wrong");  // [RL7]

  property p_invert;
    idle_go && (op == invert_all_op) |=> flags_q[FLAG_C] && (res_lo_q == ~$past(dst_val));
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong");  // [RL8]

  property p_negate;
    idle_go && (op == twos_complement_op) |=> (res_lo_q == 8'(ZERO_BYTE - $past(dst_val)))
      && (flags_q[FLAG_C] == ($past(dst_val) != ZERO_BYTE));
  endproperty
  a_negate: assert property (p_negate) else $error("negate wrong");  // [RL9]

  property p_set_mask;
    idle_go && (op == set_mask_op) |=> (res_lo_q == ($past(dst_val) | $past(imm_val)));
  endproperty
  a_set_mask: assert property (p_set_mask) else $error("set mask wrong");  // [RL10]

  property p_clear_mask;
    idle_go && (op == clear_mask_op) |=> (res_lo_q == ($past(dst_val) & ~$past(imm_val)));
  endproperty
  a_clear_mask: assert property (p_clear_mask) else $error("clear mask wrong");  // [RL11]

  property p_step_carry;
    idle_go && ((op == plus_one_op) || (op == minus_one_op)) |=>
      $stable(flags_q[FLAG_C]) && $stable(flags_q[FLAG_H]) && done_q;
  endproperty
  a_step_carry: assert property (p_step_carry) else $error("step touched carry");  // [RL12]

  property p_logic_keep;
    idle_go && (op == disjunction_immediate_op) |=> $stable(flags_q[FLAG_C])
      && $stable(flags_q[FLAG_S]) && $stable(flags_q[FLAG_H]) && wr_lo_q;
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op touched flags");  // [RL13]

endmodule // balu_core
`default_nettype wire

// >>> hdl/balu_pkg.sv
// Constants, operation codes and state types of the byte ALU.
// Assumes a single core clock and that every user imports the whole package.
package balu_pkg;

  // ==========================================================================
  // Widths and flag positions
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FLAG_W = 6;
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;

  // ==========================================================================
  // Fixed operand values and reset values
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE  = 8'h01;
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [7:0] RES_RST   = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;

  // ==========================================================================
  // Operation codes
  typedef enum logic [4:0] {
    sum_op                   = 5'h00,
    add_with_carry_op        = 5'h01,
    word_plus_immediate_op   = 5'h02,
    difference_op            = 5'h03,
    minus_immediate_op       = 5'h04,
    difference_carry_op      = 5'h05,
    minus_immediate_carry_op = 5'h06,
    word_minus_immediate_op  = 5'h07,
    conjunction_op           = 5'h08,
    conjunction_immediate_op = 5'h09,
    disjunction_op           = 5'h0A,
    disjunction_immediate_op = 5'h0B,
    exclusive_disjunction_op = 5'h0C,
    invert_all_op            = 5'h0D,
    twos_complement_op       = 5'h0E,
    set_mask_op              = 5'h0F,
    clear_mask_op            = 5'h10,
    plus_one_op              = 5'h11,
    minus_one_op             = 5'h12
  } balu_op_t;

  // Bitwise functions of the logic unit
  typedef enum logic [1:0] {
    LFN_AND = 2'h0,
    LFN_OR  = 2'h1,
    LFN_XOR = 2'h2
  } balu_lfn_t;

  // Which flags an operation touches
  typedef enum logic [2:0] {
    FC_NONE   = 3'h0,
    FC_ARITH  = 3'h1,
    FC_LOGIC  = 3'h2,
    FC_INVERT = 3'h3,
    FC_STEP   = 3'h4
  } balu_fcls_t;

  // Sequencer states
  typedef enum logic {
    ST_IDLE    = 1'b0,
    ST_WORD_HI = 1'b1
  } balu_state_t;

endpackage

// >>> hdl/balu_dp_if.sv
// Interface joining the ALU sequencer to its adder and logic unit.
// Assumes purely combinational leaves on the far side of each modport.
`timescale 1ns/1ps
`default_nettype none
interface balu_dp_if;
  import balu_pkg::*;

  // ==========================================================================
  // Adder group
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic       add_cin;
  logic       add_sub;
  logic [7:0] add_sum;
  logic       add_c;
  logic       add_h;
  logic       add_v;

  // Logic unit group
  balu_lfn_t  lfn;
  logic [7:0] lop_a;
  logic [7:0] lop_b;
  logic [7:0] lop_res;

  modport ctrl (output add_a, add_b, add_cin, add_sub, lfn, lop_a, lop_b,
                input  add_sum, add_c, add_h, add_v, lop_res);
  modport adder (input add_a, add_b, add_cin, add_sub,
                 output add_sum, add_c, add_h, add_v);
  modport logic_unit (input lfn, lop_a, lop_b, output lop_res);
endinterface
`default_nettype wire

// >>> hdl/balu_addsub.sv
// Byte adder and subtractor with carry, half carry and overflow.
// Assumes borrow-style carry out for subtraction, as the core's flags expect.
`timescale 1ns/1ps
`default_nettype none
module balu_addsub (
  balu_dp_if.adder dp
);
  import balu_pkg::*;

  logic [7:0] eff_b;
  logic       eff_c;
  logic [8:0] full;
  logic [4:0] half;

  // ==========================================================================
  // Subtract as a plus inverted b plus inverted borrow
  always_comb begin
    eff_b      = dp.add_sub ? ~dp.add_b : dp.add_b;
    eff_c      = dp.add_sub ? ~dp.add_cin : dp.add_cin;
    full       = {1'b0, dp.add_a} + {1'b0, eff_b} + {8'h00, eff_c};
    half       = {1'b0, dp.add_a[3:0]} + {1'b0, eff_b[3:0]} + {4'h0, eff_c};
    dp.add_sum = full[7:0];
    dp.add_c   = full[8] ^ dp.add_sub;  // Borrow when subtracting
    dp.add_h   = half[4] ^ dp.add_sub;
    dp.add_v   = (dp.add_a[7] == eff_b[7]) && (full[7] != dp.add_a[7]);
  end

endmodule // balu_addsub
`default_nettype wire

// >>> hdl/balu_logic.sv
// Bitwise AND, OR and XOR unit of the byte ALU.
// Assumes the sequencer forms inverted masks and constants itself.
`timescale 1ns/1ps
`default_nettype none
module balu_logic (
  balu_dp_if.logic_unit dp
);
  import balu_pkg::*;

  // ==========================================================================
  // Function select
  always_comb begin
    case (dp.lfn)
      LFN_AND: dp.lop_res = dp.lop_a & dp.lop_b;
      LFN_OR:  dp.lop_res = dp.lop_a | dp.lop_b;
      LFN_XOR: dp.lop_res = dp.lop_a ^ dp.lop_b;
      default: dp.lop_res = dp.lop_a;
    endcase
  end

endmodule // balu_logic
`default_nettype wire

// >>> test/balu_regfile_model.sv
// Register file model on the far side of the byte ALU.
// Assumes fixed slots; the pair high byte sits above the destination.
`timescale 1ns/1ps
`default_nettype none
module balu_regfile_model #(
  parameter int unsigned DST_IDX = 2,
  parameter int unsigned SRC_IDX = 7
) (
  input  wire logic       clk,
  input  wire logic       pl_en,
  input  wire logic [7:0] pl_d,
  input  wire logic [7:0] pl_dh,
  input  wire logic [7:0] pl_s,
  input  wire logic       wr_lo,
  input  wire logic       wr_hi,
  input  wire logic [7:0] res_lo,
  input  wire logic [7:0] res_hi,
  output logic [7:0]      dst_val,
  output logic [7:0]      dst_hi_val,
  output logic [7:0]      src_val
);
  logic [7:0] regs [32];

  // ==========================================================================
  // Operand reads
  assign dst_val    = regs[DST_IDX];
  assign dst_hi_val = regs[DST_IDX+1];
  assign src_val    = regs[SRC_IDX];

  // Preload, write-back wins on a shared edge
  always_ff @(posedge clk) begin
    if (pl_en) begin
      regs[DST_IDX]   <= pl_d;
      regs[DST_IDX+1] <= pl_dh;
      regs[SRC_IDX]   <= pl_s;
    end
    if (wr_lo) regs[DST_IDX] <= res_lo;
    if (wr_hi) regs[DST_IDX+1] <= res_hi;
  end
endmodule // balu_regfile_model
`default_nettype wire

// >>> test/test_balu_core.sv
// Self-checking bench for the byte ALU.
// Assumes a 125 MHz clock and async active low reset.
`timescale 1ns/1ps
`default_nettype none
module test_balu_core;
  import balu_pkg::*;

  // ==========================================================================
  // Signals and instances
  logic       clk, reset_n, start, flag_wr, pl_en;
  balu_op_t   op;
  logic [7:0] dst_val, dst_hi_val, src_val, imm_val, pl_d, pl_dh, pl_s;
  logic [7:0] res_lo_q, res_hi_q;
  logic [5:0] flag_in, flags_q, f_exp;
  logic       wr_lo_q, wr_hi_q, done_q, busy_q;
  int         err_total = 0, cmp_count = 0;

  balu_core u_balu_core (.clk, .reset_n, .start, .op, .dst_val, .dst_hi_val, .src_val,
    .imm_val, .flag_wr, .flag_in, .res_lo_q, .res_hi_q, .wr_lo_q, .wr_hi_q, .flags_q,
    .done_q, .busy_q);

  balu_regfile_model u_balu_regfile_model (.clk, .pl_en, .pl_d, .pl_dh, .pl_s,
    .wr_lo(wr_lo_q), .wr_hi(wr_hi_q), .res_lo(res_lo_q), .res_hi(res_hi_q), .dst_val,
    .dst_hi_val, .src_val);

  // ==========================================================================
  // Reference model: {flags, high, low}
  function automatic logic [21:0] expect_of(input balu_op_t o,
      input logic [7:0] d, dh, s, k, input logic [5:0] fi);
    logic [7:0]  a, b, r, rh;
    logic [8:0]  r9;
    logic [4:0]  h5;
    logic [15:0] w;
    logic [5:0]  f;
    logic        sub, cin, ar, pw;
    {f, a, b, r, rh, sub, ar} = {fi, d, s, d, dh, 2'b00};
    pw = (o == word_plus_immediate_op);
    cin = f[FLAG_C] & (o inside {add_with_carry_op, difference_carry_op,
                                 minus_immediate_carry_op});
    if (o inside {minus_immediate_op, minus_immediate_carry_op}) b = k;
    if (o == twos_complement_op) begin
      a = 8'h00;
      b = d;
    end
    case (o)
      sum_op, add_with_carry_op: ar = 1'b1;
      difference_op, difference_carry_op, minus_immediate_op, minus_immediate_carry_op,
      twos_complement_op: begin
        ar = 1'b1;
        sub = 1'b1;
      end
      conjunction_op: r = d & s;
      conjunction_immediate_op: r = d & k;
      disjunction_op: r = d | s;
      disjunction_immediate_op, set_mask_op: r = d | k;
      exclusive_disjunction_op: r = d ^ s;
      clear_mask_op: r = d & (8'hFF - k);
      invert_all_op: r = 8'hFF - d;
      plus_one_op: r = d + 8'h01;
      minus_one_op: r = d - 8'h01;
      default: ;
    endcase
    if (ar) begin
      r9 = sub ? {1'b0, a} - {1'b0, b} - 9'(cin) : {1'b0, a} + {1'b0, b} + 9'(cin);
      h5 = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin)
               : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
      r = r9[7:0];
      f[FLAG_C] = r9[8];
      f[FLAG_H] = h5[4];
      f[FLAG_V] = (a[7] ^ b[7] ^ ~sub) & (r[7] ^ a[7]);
    end
    if (o == invert_all_op) f[FLAG_C] = 1'b1;
    if (o == plus_one_op) f[FLAG_V] = (r == 8'h80);
    if (o == minus_one_op) f[FLAG_V] = (r == 8'h7F);
    if (!ar && !(o inside {plus_one_op, minus_one_op})) f[FLAG_V] = 1'b0;
    f[FLAG_Z] = (r == 8'h00);
    f[FLAG_N] = r[7];
    if (o inside {word_plus_immediate_op, word_minus_immediate_op}) begin
      w = pw ? {dh, d} + {8'h00, k} : {dh, d} - {8'h00, k};
      {rh, r} = w;
      f[FLAG_C] = pw ? (~w[15] & dh[7]) : (w[15] & ~dh[7]);
      f[FLAG_V] = pw ? (~dh[7] & w[15]) : (dh[7] & ~w[15]);
      f[FLAG_Z] = (w == 16'h0000);
      f[FLAG_N] = w[15];
      f[FLAG_S] = w[15] ^ f[FLAG_V];
    end
    return {f, rh, r};
  endfunction

  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic load(input logic [7:0] d, dh, s);
    @(posedge clk);
    pl_en <= 1'b1;
    pl_d  <= d;
    pl_dh <= dh;
    pl_s  <= s;
    @(posedge clk);
    pl_en <= 1'b0;
  endtask

  task automatic set_flags(input logic [5:0] v);
    @(posedge clk);
    flag_wr <= 1'b1;
    flag_in <= v;
    @(posedge clk);
    flag_wr <= 1'b0;
    #1;
    check("flag_load", flags_q, v);
    f_exp = v;
  endtask

  task automatic run_op(input balu_op_t o, input logic [7:0] d, dh, s, k);
    logic [21:0] e;
    logic        wd;
    int          n = 0;
    e  = expect_of(o, d, dh, s, k, f_exp);
    wd = o inside {word_plus_immediate_op, word_minus_immediate_op};
    load(d, dh, s);
    start   <= 1'b1;
    op      <= o;
    imm_val <= k;
    @(posedge clk);
    start <= 1'b0;
    #1;
    if (wd) check("busy", busy_q, 1'b1);
    while (done_q !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      err_total++;
      tally_and_finish();
    end
    check("cycles", 16'(n), {15'h0, wd});
    check("wr_lo", wr_lo_q, 1'b1);
    check("wr_hi", wr_hi_q, wd);
    check("res_lo", res_lo_q, e[7:0]);
    if (wd) check("res_hi", res_hi_q, e[15:8]);
    check("flags", flags_q, e[21:16]);
    f_exp = e[21:16];
    @(posedge clk);
    #1;
    check("done_end", done_q, 1'b0);
    check("wb_lo", u_balu_regfile_model.regs[2], e[7:0]);
    if (wd) check("wb_hi", u_balu_regfile_model.regs[3], e[15:8]);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    #1;
    check("rst_flags", flags_q, 6'h0);
    check("rst_res", {res_hi_q, res_lo_q}, 16'h0);
    check("rst_strobes", {wr_lo_q, wr_hi_q, done_q, busy_q}, 4'h0);
    $display("test reset done");
  endtask

  task automatic t_arith;
    balu_op_t   ops [7] = '{sum_op, add_with_carry_op, difference_op, minus_immediate_op,
                            difference_carry_op, minus_immediate_carry_op,
                            twos_complement_op};
    logic [7:0] da [5] = '{8'h7F, 8'hFF, 8'h0F, 8'h80, 8'h00};
    logic [7:0] sa [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
    set_flags(6'h10);
    foreach (ops[i]) foreach (da[j]) run_op(ops[i], da[j], 8'h00, sa[j], sa[j]);
    $display("test arith done");
  endtask

  task automatic t_logic;
    balu_op_t   ops [8] = '{conjunction_op, conjunction_immediate_op, disjunction_op,
                            disjunction_immediate_op, exclusive_disjunction_op,
                            set_mask_op, clear_mask_op, invert_all_op};
    logic [7:0] da [3] = '{8'hA5, 8'h80, 8'hFF};
    logic [7:0] sa [3] = '{8'h5A, 8'h80, 8'h00};
    logic [7:0] ka [3] = '{8'h0F, 8'h7F, 8'hFF};
    set_flags(6'h3E);
    foreach (ops[i]) foreach (da[j]) run_op(ops[i], da[j], 8'h00, sa[j], ka[j]);
    $display("test logic done");
  endtask

  task automatic t_step;
    logic [7:0] da [5] = '{8'h7F, 8'h80, 8'hFF, 8'h00, 8'h01};
    set_flags(6'h31);
    foreach (da[j]) run_op(plus_one_op, da[j], 8'h0, 8'h0, 8'h0);
    foreach (da[j]) run_op(minus_one_op, da[j], 8'h0, 8'h0, 8'h0);
    $display("test step done");
  endtask

  task automatic t_word;
    logic [7:0] dl [5] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h34};
    logic [7:0] dh [5] = '{8'hFF, 8'h7F, 8'h00, 8'h80, 8'h12};
    logic [7:0] ka [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h3F};
    set_flags(6'h20);
    foreach (dl[j]) run_op(word_plus_immediate_op, dl[j], dh[j], 8'h0, ka[j]);
    foreach (dl[j]) run_op(word_minus_immediate_op, dl[j], dh[j], 8'h0, ka[j]);
    $display("test word done");
  endtask

  task automatic t_b2b;
    logic [21:0] e1, e2;
    e1 = expect_of(sum_op, 8'h10, 8'h0, 8'h22, 8'h0, f_exp);
    e2 = expect_of(difference_op, 8'h10, 8'h0, 8'h22, 8'h0, e1[21:16]);
    load(8'h10, 8'h00, 8'h22);
    start   <= 1'b1;
    op      <= sum_op;
    flag_wr <= 1'b1;
    flag_in <= 6'h15;
    @(posedge clk);
    op      <= difference_op;
    flag_wr <= 1'b0;
    #1;
    check("b2b_first", {done_q, res_lo_q, flags_q}, {1'b1, e1[7:0], e1[21:16]});
    @(posedge clk);
    start <= 1'b0;
    #1;
    check("b2b_second", {done_q, res_lo_q, flags_q}, {1'b1, e2[7:0], e2[21:16]});
    f_exp = e2[21:16];
    $display("test b2b done");
  endtask

  task automatic t_busy;
    logic [21:0] e;
    int          dones = 0;
    e = expect_of(word_plus_immediate_op, 8'hF0, 8'h01, 8'h00, 8'h20, f_exp);
    load(8'hF0, 8'h01, 8'h00);
    start   <= 1'b1;
    op      <= word_plus_immediate_op;
    imm_val <= 8'h20;
    @(posedge clk);
    op <= sum_op;
    @(posedge clk);
    start <= 1'b0;
    repeat (4) begin
      #1;
      dones += (done_q === 1'b1);
      @(posedge clk);
    end
    check("busy_dones", 16'(dones), 16'h1);
    check("busy_res", {res_hi_q, res_lo_q}, e[15:0]);
    check("busy_flags", flags_q, e[21:16]);
    f_exp = e[21:16];
    $display("test busy done");
  endtask

  task automatic t_bad;
    int dones = 0;
    @(posedge clk);
    start <= 1'b1;
    op    <= balu_op_t'(5'h15);
    @(posedge clk);
    start <= 1'b0;
    repeat (3) begin
      #1;
      dones += (done_q === 1'b1);
      @(posedge clk);
    end
    check("bad_done", 16'(dones), 16'h0);
    check("bad_flags", flags_q, f_exp);
    $display("test bad done");
  endtask

  // ==========================================================================
  // Clock, reset and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {reset_n, start, flag_wr, pl_en, imm_val, flag_in, pl_d, pl_dh, pl_s, f_exp} = '0;
    op = sum_op;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_arith();
    t_logic();
    t_step();
    t_word();
    t_b2b();
    t_busy();
    t_bad();
    tally_and_finish();
  end
endmodule // test_balu_core
`default_nettype wire
